/* inc/osr_pkg.sv */
package osr_pkg;
  // Register indices on the plain register port
  localparam logic [3:0]  ADDR_ROUTE_TWO    = 4'h0;
  localparam logic [3:0]  ADDR_ROUTE_THREE  = 4'h1;
  localparam logic [3:0]  ADDR_ACTIVE_TWO   = 4'h2;
  localparam logic [3:0]  ADDR_ACTIVE_THREE = 4'h3;
  localparam logic [3:0]  ADDR_RESTART      = 4'h4;
  localparam logic [3:0]  ADDR_STATUS       = 4'h5;
  localparam int          ADDR_W            = 4;
  localparam int          DATA_W            = 16;
  localparam int          TERM_N            = 6;
  localparam int          SIG_N             = 7;
  // Digit coding
  localparam logic [3:0]  DIGIT_OFF         = 4'h6;
  localparam logic [3:0]  DIGIT_MAX         = 4'h6;
  // Factory values, BCD, per axis
  localparam logic [15:0] ROUTE_TWO_AXIS_A   = 16'h6611;
  localparam logic [15:0] ROUTE_TWO_AXIS_B   = 16'h6644;
  localparam logic [15:0] ROUTE_THREE_AXIS_A = 16'h0666;
  localparam logic [15:0] ROUTE_THREE_AXIS_B = 16'h3666;
  // Value held before the factory load
  localparam logic [15:0] ROUTE_RESET        = 16'h6666;
  // Digit field positions
  localparam int          DIG0_LSB = 0;
  localparam int          DIG1_LSB = 4;
  localparam int          DIG2_LSB = 8;
  localparam int          DIG3_LSB = 12;
  // Restart command bit and status bits
  localparam int          RESTART_BIT      = 0;
  localparam int          STAT_PENDING_BIT = 0;
  localparam int          STAT_AXIS_BIT    = 1;
  localparam int          STAT_BADWR_BIT   = 2;
  localparam int          STAT_TERM_LSB    = 8;
endpackage : osr_pkg

/* rtl/osr_route_cell.sv */
`timescale 1ns/1ps
`default_nettype none
// One routing digit: decodes a digit into a terminal select mask.
module osr_route_cell
  import osr_pkg::*;
(
  input  wire logic [3:0]        digit,
  input  wire logic              sig_in,
  output logic      [TERM_N-1:0] term_mask
);
  genvar t;
  generate
    for (t = 0; t < TERM_N; t++) begin : g_term
      assign term_mask[t] = sig_in & (digit == 4'(t));
    end
  endgenerate
endmodule : osr_route_cell
`default_nettype wire

/* rtl/osr_output_router.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Word two digits 0..6, factory 6611/6644
// - Digit n 0..5 drives terminal n
// - Digit 6 routes signal nowhere
// - Word two second digit: speed limit
// - Word two third digit: warning
// - Word three factory 0666/3666, restart applies
// - Word three lowest digit: position_out_a position
// - Word three second digit: index pulse
// - Word three third digit: multiplier switch
// - Word three highest digit: fault
module osr_output_router
  import osr_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      axis_b_sel,
  input  wire logic [osr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [osr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [osr_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                      torque_limit_detect_out,
  input  wire logic                      speed_limit_detect_out,
  input  wire logic                      warning_out,
  input  wire logic                      position_out_a,
  input  wire logic                      encoder_index_pulse_out,
  input  wire logic                      pulse_multiplier_switch_out,
  input  wire logic                      fault_out,
  output logic                           gp_output_terminal_0,
  output logic                           gp_output_terminal_1,
  output logic                           gp_output_terminal_2,
  output logic                           gp_output_terminal_3,
  output logic                           gp_output_terminal_4,
  output logic                           gp_output_terminal_5
);
  import osr_pkg::*;

  typedef enum logic [1:0] {OSR_RESET, OSR_LOAD, OSR_RUN} osr_state_t;

  function automatic logic digit_valid(input logic [3:0] d);
    digit_valid = (d <= DIGIT_MAX);
  endfunction : digit_valid

  function automatic logic [3:0] field_of(input logic [15:0] w, input int lsb);
    field_of = w[lsb+:4];
  endfunction : field_of

  function automatic logic digits_ok(input logic [15:0] w);
    digits_ok = digit_valid(w[DIG0_LSB+:4]) && digit_valid(w[DIG1_LSB+:4]) &&
                digit_valid(w[DIG2_LSB+:4]) && digit_valid(w[DIG3_LSB+:4]);
  endfunction : digits_ok

  // Reset release
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Pin synchronisers: 7 sources
  logic [SIG_N-1:0] src_raw;
  logic [SIG_N-1:0] src_s1;
  logic [SIG_N-1:0] src;
  assign src_raw = {fault_out, pulse_multiplier_switch_out, encoder_index_pulse_out,
                    position_out_a, warning_out, speed_limit_detect_out,
                    torque_limit_detect_out};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_s1 <= '0;
      src    <= '0;
    end else begin
      src_s1 <= src_raw;
      src    <= src_s1;
    end
  end

  // Axis strap: no reset, so it is settled when the factory load happens
  logic axis_s1;
  logic axis_s2;
  always_ff @(posedge clk) begin
    axis_s1 <= axis_b_sel;
    axis_s2 <= axis_s1;
  end

  // Stored words and active copies
  logic [15:0] route_two;
  logic [15:0] route_three;
  logic [15:0] active_two;
  logic [15:0] active_three;
  logic        pending;
  logic        bad_write;
  osr_state_t  state;
  osr_state_t  next_state;

  wire wr_two     = reg_wr && (reg_addr == ADDR_ROUTE_TWO);
  wire wr_three   = reg_wr && (reg_addr == ADDR_ROUTE_THREE);
  wire wr_restart = reg_wr && (reg_addr == ADDR_RESTART) && reg_wdata[RESTART_BIT];
  wire wr_word    = wr_two || wr_three;
  wire wr_good    = wr_word && digits_ok(reg_wdata);
  wire wr_bad     = wr_word && !digits_ok(reg_wdata);
  wire rd_status  = reg_rd && (reg_addr == ADDR_STATUS);
  wire wdata_ok   = digits_ok(reg_wdata);
  wire [15:0] fact_two   = axis_s2 ? ROUTE_TWO_AXIS_B : ROUTE_TWO_AXIS_A;
  wire [15:0] fact_three = axis_s2 ? ROUTE_THREE_AXIS_B : ROUTE_THREE_AXIS_A;

  always_comb begin
    case (state)
      OSR_RESET: next_state = OSR_LOAD;
      OSR_LOAD:  next_state = OSR_RUN;
      OSR_RUN:   next_state = wr_restart ? OSR_LOAD : OSR_RUN;
      default:   next_state = OSR_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= OSR_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Software words: factory value caught in the first cycle after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      route_two <= ROUTE_RESET;
    end else if (state == OSR_RESET) begin
      route_two <= fact_two;
    end else if (wr_two && wdata_ok) begin
      route_two <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      route_three <= ROUTE_RESET;
    end else if (state == OSR_RESET) begin
      route_three <= fact_three;
    end else if (wr_three && wdata_ok) begin
      route_three <= reg_wdata;
    end
  end

  // Active words change only on a load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_two <= ROUTE_RESET;
    end else if (state == OSR_LOAD) begin
      active_two <= route_two;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_three <= ROUTE_RESET;
    end else if (state == OSR_LOAD) begin
      active_three <= route_three;
    end
  end

  // Pending: set by an accepted word write, cleared by a load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else if (wr_good) begin
      pending <= 1'b1;
    end else if (state == OSR_LOAD) begin
      pending <= 1'b0;
    end
  end

  // Refused write: a new refusal wins over the clearing status read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_write <= 1'b0;
    end else if (wr_bad) begin
      bad_write <= 1'b1;
    end else if (rd_status) begin
      bad_write <= 1'b0;
    end
  end

  // Routing: one cell per signal
  logic [3:0]        digit [SIG_N];
  logic [TERM_N-1:0] mask  [SIG_N];
  assign digit[0] = field_of(active_two, DIG0_LSB);
  assign digit[1] = field_of(active_two, DIG1_LSB);
  assign digit[2] = field_of(active_two, DIG2_LSB);
  assign digit[3] = field_of(active_three, DIG0_LSB);
  assign digit[4] = field_of(active_three, DIG1_LSB);
  assign digit[5] = field_of(active_three, DIG2_LSB);
  assign digit[6] = field_of(active_three, DIG3_LSB);

  genvar s;
  generate
    for (s = 0; s < SIG_N; s++) begin : g_sig
      osr_route_cell u_cell (
        .digit     (digit[s]),
        .sig_in    (src[s]),
        .term_mask (mask[s])
      );
    end
  endgenerate

  logic [TERM_N-1:0] next_term;
  always_comb begin
    next_term = '0;
    for (int i = 0; i < SIG_N; i++) begin
      next_term = next_term | mask[i];
    end
  end

  logic [TERM_N-1:0] term;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      term <= '0;
    end else if (state == OSR_RUN) begin
      term <= next_term;
    end else begin
      term <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gp_output_terminal_0 <= 1'b0;
      gp_output_terminal_1 <= 1'b0;
      gp_output_terminal_2 <= 1'b0;
      gp_output_terminal_3 <= 1'b0;
      gp_output_terminal_4 <= 1'b0;
      gp_output_terminal_5 <= 1'b0;
    end else begin
      gp_output_terminal_0 <= term[0];
      gp_output_terminal_1 <= term[1];
      gp_output_terminal_2 <= term[2];
      gp_output_terminal_3 <= term[3];
      gp_output_terminal_4 <= term[4];
      gp_output_terminal_5 <= term[5];
    end
  end

  // Register read port
  logic [15:0] next_rdata;
  wire  [TERM_N-1:0] stat_term   = term;
  wire  [4:0]        stat_spare  = 5'b0_0000;
  wire  [2:0]        stat_flags  = {bad_write, axis_s2, pending};
  wire  [15:0]       status_word = {2'b00, stat_term, stat_spare, stat_flags};
  always_comb begin
    case (reg_addr)
      ADDR_ROUTE_TWO:    next_rdata = route_two;
      ADDR_ROUTE_THREE:  next_rdata = route_three;
      ADDR_ACTIVE_TWO:   next_rdata = active_two;
      ADDR_ACTIVE_THREE: next_rdata = active_three;
      ADDR_STATUS:       next_rdata = status_word;
      default:           next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : osr_output_router
`default_nettype wire

/* bench/osr_output_router_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module osr_output_router_chk
  import osr_pkg::*;
(
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              axis_b_sel,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  function automatic logic ok(input logic [15:0] w);
    return w[3:0] <= DIGIT_MAX && w[7:4] <= DIGIT_MAX && w[11:8] <= DIGIT_MAX && w[15:12] <= DIGIT_MAX;
  endfunction : ok
  sequence rd_at(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence wr_two;
    reg_wr && reg_addr == ADDR_ROUTE_TWO && ok(reg_wdata);
  endsequence
  sequence apply_two;
    wr_two ##2 reg_wr && reg_addr == ADDR_ROUTE_THREE ##2 reg_wr && reg_addr == ADDR_RESTART && reg_wdata[0];
  endsequence
  idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside answer");
  unmapped_zero_a: assert property (reg_rd && reg_addr > ADDR_STATUS |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  stored_word_a: assert property (wr_two ##2 rd_at(ADDR_ROUTE_TWO) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("stored word lost");
  bad_flag_a: assert property (reg_wr && reg_addr == ADDR_ROUTE_TWO && !ok(reg_wdata) ##2 rd_at(ADDR_STATUS)
    |=> reg_rdata[STAT_BADWR_BIT]) else $error("bad write not flagged");
  flag_clear_a: assert property (rd_at(ADDR_STATUS) ##1 !reg_wr ##1 rd_at(ADDR_STATUS)
    |=> !reg_rdata[STAT_BADWR_BIT]) else $error("bad write flag stuck");
  axis_status_a: assert property (rd_at(ADDR_STATUS) |=> reg_rdata[STAT_AXIS_BIT] == $past(axis_b_sel))
    else $error("axis status wrong");
  active_digits_a: assert property (rd_at(ADDR_ACTIVE_TWO) or rd_at(ADDR_ACTIVE_THREE) |=> ok(reg_rdata))
    else $error("active digit above six");
  applied_word_a: assert property (apply_two ##2 rd_at(ADDR_ACTIVE_TWO) |=> reg_rdata == $past(reg_wdata, 7))
    else $error("restart did not apply word");
endmodule : osr_output_router_chk
bind osr_output_router osr_output_router_chk i_osr_output_router_chk (.*);
`default_nettype wire

/* bench/osr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host inputs latching the six terminals
module osr_host_model (
  input  wire logic       clk,
  input  wire logic [5:0] term_in,
  output var  logic [5:0] seen
);
  always_ff @(posedge clk) begin
    seen <= term_in;
  end
endmodule : osr_host_model
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import osr_pkg::*;
  logic        clk;
  logic        arst_n;
  logic        axis_b_sel;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [6:0]  src;
  logic [5:0]  term;
  logic [5:0]  seen;
  logic [15:0] v;
  logic [15:0] w;
  int          d;
  int          err_total;
  int          check_count;
  osr_output_router i_osr_output_router (.clk(clk), .arst_n(arst_n), .axis_b_sel(axis_b_sel), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .torque_limit_detect_out(src[0]), .speed_limit_detect_out(src[1]), .warning_out(src[2]),
    .position_out_a(src[3]), .encoder_index_pulse_out(src[4]), .pulse_multiplier_switch_out(src[5]),
    .fault_out(src[6]), .gp_output_terminal_0(term[0]), .gp_output_terminal_1(term[1]),
    .gp_output_terminal_2(term[2]), .gp_output_terminal_3(term[3]), .gp_output_terminal_4(term[4]),
    .gp_output_terminal_5(term[5]));
  osr_host_model i_osr_host_model (.clk(clk), .term_in(term), .seen(seen));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] dat);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    dat = reg_rdata;
  endtask : rd
  task automatic results;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    arst_n = 1'b0;
    axis_b_sel = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    src = 7'h00;
    err_total = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(ADDR_ROUTE_TWO, v);
    chk(v, ROUTE_TWO_AXIS_A);
    rd(ADDR_ACTIVE_THREE, v);
    chk(v, ROUTE_THREE_AXIS_A);
    $display("Test factory done");
    for (int s = 0; s < 7; s++) begin
      for (int n = 0; n < 7; n++) begin
        d = (s < 3) ? s : s - 3;
        w = (16'h6666 & ~(16'h000f << (4 * d))) | (16'(n) << (4 * d));
        wr(ADDR_ROUTE_TWO, (s < 3) ? w : 16'h6666);
        wr(ADDR_ROUTE_THREE, (s < 3) ? 16'h6666 : w);
        wr(ADDR_RESTART, 16'h0001);
        rd((s < 3) ? ADDR_ACTIVE_TWO : ADDR_ACTIVE_THREE, v);
        chk(v, w);
        @(posedge clk);
        src <= 7'h01 << s;
        repeat (8) @(posedge clk);
        chk({10'h000, seen}, (n < 6) ? 16'h0001 << n : 16'h0000);
        src <= 7'h00;
        repeat (6) @(posedge clk);
      end
    end
    $display("Test routing done");
    wr(ADDR_ROUTE_TWO, 16'h6617);
    rd(ADDR_STATUS, v);
    chk(v & 16'h0006, 16'h0004);
    rd(ADDR_STATUS, v);
    chk(v & 16'h0006, 16'h0000);
    rd(ADDR_ROUTE_TWO, v);
    chk(v, 16'h6666);
    wr(ADDR_ROUTE_TWO, 16'h6605);
    rd(ADDR_ROUTE_TWO, v);
    chk(v, 16'h6605);
    rd(4'hf, v);
    chk(v, 16'h0000);
    rd(ADDR_ACTIVE_TWO, v);
    chk(v, 16'h6666);
    rd(ADDR_STATUS, v);
    chk(v & 16'h0001, 16'h0001);
    $display("Test refusal done");
    @(posedge clk);
    axis_b_sel <= 1'b1;
    src        <= 7'h40;
    arst_n     <= 1'b0;
    repeat (4) @(posedge clk);
    chk({10'h000, seen}, 16'h0000);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(ADDR_ROUTE_TWO, v);
    chk(v, ROUTE_TWO_AXIS_B);
    rd(ADDR_ACTIVE_THREE, v);
    chk(v, ROUTE_THREE_AXIS_B);
    rd(ADDR_STATUS, v);
    chk(v & 16'h0007, 16'h0002);
    chk(v & 16'h3f00, 16'h0800);
    chk({10'h000, seen}, 16'h0008);
    $display("Test axis B done");
    results();
  end
endmodule : testbench
`default_nettype wire
